// *** verilog/lpmc_pkg.sv ***
// constants and types of the low power mode controller
package lpmc_pkg;
   // register offsets on the internal register port
   localparam logic [11:0] WAKE_UP_CONTROL_OFF        = 12'h0f7;
   localparam logic [11:0] OPERATION_MODE_CONTROL_OFF = 12'h0fa;
   localparam logic [11:0] POWER_DOWN_OPERAND_OFF     = 12'h0fb;
   localparam logic [11:0] POWER_DOWN_BUS_DRIVE_OFF   = 12'h82a;
   // operation_mode_control fields
   localparam int OMC_WP_BIT   = 7;
   localparam int OMC_DF_LSB   = 3;
   localparam int OMC_HALF_BIT = 2;
   localparam int OMC_LPM_LSB  = 0;
   localparam logic [7:0] OMC_RESET = 8'h00;
   // power_down_bus_drive fields
   localparam int PDB_EN_BIT   = 0;
   localparam int PDB_DL_BIT   = 1;
   localparam int PDB_AL_BIT   = 2;
   localparam logic [7:0] PDB_RESET = 8'h00;
   localparam logic [7:0] PDO_RESET = 8'h00;
   // wake_up_control fields
   localparam int WUC_PA_EN  = 0;
   localparam int WUC_PB_EN  = 1;
   localparam int WUC_TM_EN  = 2;
   localparam int WUC_PA_EV  = 4;
   localparam int WUC_PB_EV  = 5;
   localparam int WUC_TM_EV  = 6;
   localparam logic [7:0] WUC_RESET = 8'h00;
   localparam logic [7:0] WUC_RW_MASK = 8'h07;
   // supervisor data function code bit
   localparam int FC_SUPER_BIT = 2;
   localparam logic [2:0] WAKE_IRQ_LEVEL = 3'h4;
   // core stop completion wait
   localparam int STOP_WAIT_CLKS = 16;
   localparam logic [4:0] STOP_WAIT_CNT = 5'(STOP_WAIT_CLKS);
   // power mode encodings
   localparam logic [1:0] LPM_NORMAL  = 2'h0;
   localparam logic [1:0] LPM_STANDBY = 2'h1;
   localparam logic [1:0] LPM_DOZE    = 2'h2;
   localparam logic [1:0] LPM_STOP    = 2'h3;

   typedef enum logic [2:0] {
      LPMC_RUN  = 3'b000,
      LPMC_WAIT = 3'b001,
      LPMC_BREQ = 3'b010,
      LPMC_DOWN = 3'b011,
      LPMC_WAKE = 3'b100
   } lpmc_state_e;

   typedef struct packed {
      lpmc_state_e state;
      logic [7:0]  omc;
      logic [7:0]  pdb;
      logic [7:0]  pdo;
      logic [7:0]  wuc;
      logic [2:0]  mask;
      logic [4:0]  cnt;
      logic [15:0] div_cnt;
      logic        div_tick;
      logic        half_tog;
      logic        pa_s1;
      logic        pa_s2;
      logic        pa_s3;
      logic        pb_s1;
      logic        pb_s2;
      logic        pb_s3;
      logic        hr_s1;
      logic        hr_s2;
      logic        ht_s1;
      logic        ht_s2;
      logic [7:0]  rdata;
   } lpmc_state_s;
endpackage

// *** verilog/lpmc_controller.sv ***
// low power mode controller: mode register, stop sequence and wake-up
// Summary of operation
// - write-protect clears at reset; once set, later mode register writes ignored
// - system clock divided by two to the power of the divide factor
// - zero divide factor is normal, non-zero slow
// - rate clock passes undivided when halving bit 0, halved when 1
// - supervisor operand write enters mode from power mode field: standby/doze/stop; normal is refused
// - in power-down, buses float if drive enable 0, driven if 1
// - data bus driven high when data level bit 0, low when 1
// - address bus driven high when address level bit 0, low when 1
// - operand write always stored; power-down entry only from supervisor space
// - operand mask bits latched; higher interrupt during stopping aborts
// - count 16 clocks after request; grant activity restarts the count
// - after count, request bus, await grant, then force power-down
// - hard reset, enabled pin falling edge or enabled timer timeout wakes
// - wake restarts clocks, releases host bus, returns to normal
// - wake during stop execution abandons the sequence
// - pin and timer wake interrupts raised at level 4
// - pin a falling edge sets its event; write one clears
// - pin b falling edge sets its event; write one clears
// - timer timeout sets its event; write one clears
// - event and enable both set: wake, interrupt, refuse power-down entry
// - mode register: protect 7, divide 6:3, halving 2, mode 1:0
`timescale 1ns/1ps
`default_nettype none
module lpmc_controller (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic [2:0]  reg_fc,
   output logic      [7:0]  reg_rdata,
   input  wire logic        stop_exec,
   input  wire logic [2:0]  core_irq_level,
   input  wire logic        bus_grant_n,
   input  wire logic        bus_grant_acknowledge_n,
   output logic             bus_request_n,
   input  wire logic        wake_pin_a,
   input  wire logic        wake_pin_b,
   input  wire logic        hard_reset_n,
   input  wire logic        halt_n,
   input  wire logic        timer_timeout,
   input  wire logic        serial_rate_clk_en,
   output logic             serial_rate_tick,
   output logic             sys_clk_tick,
   output logic             slow_mode,
   output logic      [1:0]  power_mode,
   output logic             clocks_stopped,
   output logic      [2:0]  wake_irq_level,
   output logic             wake_pin_a_irq,
   output logic             wake_pin_b_irq,
   output logic             timer_wake_irq,
   output logic             data_bus_oe,
   output logic             data_bus_level,
   output logic             addr_bus_oe,
   output logic             addr_bus_level
);
   lpmc_pkg::lpmc_state_s q;
   lpmc_pkg::lpmc_state_s d;

   logic       wr_omc;
   logic       wr_pdb;
   logic       wr_pdo;
   logic       wr_wuc;
   logic       pa_fall;
   logic       pb_fall;
   logic [2:0] live;
   logic       wake;
   logic       grant_act;
   logic       irq_abort;
   logic [3:0] df;
   logic [15:0] div_max;
   logic        super_wr;
   logic        mode_set;
   logic        hard_wake;
   logic        entry_ok;
   logic        count_done;
   logic        seq_abort;

   // ----------------------------------------------------------------
   // decode and wake conditions
   // ----------------------------------------------------------------
   always_comb begin
      wr_omc = reg_wr && reg_addr == lpmc_pkg::OPERATION_MODE_CONTROL_OFF;
      wr_pdb = reg_wr && reg_addr == lpmc_pkg::POWER_DOWN_BUS_DRIVE_OFF;
      wr_pdo = reg_wr && reg_addr == lpmc_pkg::POWER_DOWN_OPERAND_OFF;
      wr_wuc = reg_wr && reg_addr == lpmc_pkg::WAKE_UP_CONTROL_OFF;
      pa_fall = q.pa_s3 && !q.pa_s2;
      pb_fall = q.pb_s3 && !q.pb_s2;
      // each source live when event and enable both set
      live[0] = q.wuc[lpmc_pkg::WUC_PA_EV] && q.wuc[lpmc_pkg::WUC_PA_EN];
      live[1] = q.wuc[lpmc_pkg::WUC_PB_EV] && q.wuc[lpmc_pkg::WUC_PB_EN];
      live[2] = q.wuc[lpmc_pkg::WUC_TM_EV] && q.wuc[lpmc_pkg::WUC_TM_EN];
      // hard reset wakes only with reset and halt both low
      hard_wake = !q.hr_s2 && !q.ht_s2;
      wake = (|live) || hard_wake;
      grant_act = !bus_grant_n || !bus_grant_acknowledge_n;
      irq_abort = core_irq_level > q.mask;
      // supervisor data cycle only
      super_wr = wr_pdo && reg_fc[lpmc_pkg::FC_SUPER_BIT]
                 && !reg_fc[1] && reg_fc[0];
      mode_set = q.omc[lpmc_pkg::OMC_LPM_LSB +: 2]
                 != lpmc_pkg::LPM_NORMAL;
      entry_ok = super_wr && mode_set && !wake;
      count_done = q.cnt == lpmc_pkg::STOP_WAIT_CNT - 5'h01;
      seq_abort = wake || irq_abort;
      df = q.omc[lpmc_pkg::OMC_DF_LSB +: 4];
      div_max = 16'((17'h1 << df) - 17'h1);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.pa_s1 = wake_pin_a;
      d.pa_s2 = q.pa_s1;
      d.pa_s3 = q.pa_s2;
      d.pb_s1 = wake_pin_b;
      d.pb_s2 = q.pb_s1;
      d.pb_s3 = q.pb_s2;
      // reset and halt pins synchronised apart before any logic reads them
      d.hr_s1 = hard_reset_n;
      d.hr_s2 = q.hr_s1;
      d.ht_s1 = halt_n;
      d.ht_s2 = q.ht_s1;

      // divide factor zero gives a tick every clock
      if (q.div_cnt >= div_max) begin
         d.div_cnt = 16'h0000;
         d.div_tick = 1'b1;
      end else begin
         d.div_cnt = q.div_cnt + 16'h0001;
         d.div_tick = 1'b0;
      end
      if (serial_rate_clk_en) begin
         d.half_tog = !q.half_tog;
      end

      if (wr_omc && !q.omc[lpmc_pkg::OMC_WP_BIT]) begin
         d.omc = reg_wdata;
      end
      if (wr_pdb) begin
         d.pdb = reg_wdata;
      end
      if (wr_pdo) begin
         d.pdo = reg_wdata;
      end

      // event bits: write one clears, hardware set wins
      if (wr_wuc) begin
         // enables take the written value
         d.wuc[lpmc_pkg::WUC_PA_EN] = reg_wdata[lpmc_pkg::WUC_PA_EN];
         d.wuc[lpmc_pkg::WUC_PB_EN] = reg_wdata[lpmc_pkg::WUC_PB_EN];
         d.wuc[lpmc_pkg::WUC_TM_EN] = reg_wdata[lpmc_pkg::WUC_TM_EN];
         // a one clears an event, a zero leaves it
         if (reg_wdata[lpmc_pkg::WUC_PA_EV]) begin
            d.wuc[lpmc_pkg::WUC_PA_EV] = 1'b0;
         end
         if (reg_wdata[lpmc_pkg::WUC_PB_EV]) begin
            d.wuc[lpmc_pkg::WUC_PB_EV] = 1'b0;
         end
         if (reg_wdata[lpmc_pkg::WUC_TM_EV]) begin
            d.wuc[lpmc_pkg::WUC_TM_EV] = 1'b0;
         end
      end
      if (pa_fall) begin
         d.wuc[lpmc_pkg::WUC_PA_EV] = 1'b1;
      end
      if (pb_fall) begin
         d.wuc[lpmc_pkg::WUC_PB_EV] = 1'b1;
      end
      if (timer_timeout) begin
         d.wuc[lpmc_pkg::WUC_TM_EV] = 1'b1;
      end

      case (q.state)
         lpmc_pkg::LPMC_RUN: begin
            // supervisor write with a power mode and no live wake
            if (entry_ok) begin
               d.mask = reg_wdata[2:0];
               d.cnt = 5'h00;
               d.state = lpmc_pkg::LPMC_WAIT;
            end
         end
         lpmc_pkg::LPMC_WAIT: begin
            // core still finishing its stop instruction
            if (seq_abort) begin
               d.state = lpmc_pkg::LPMC_RUN;
            end else if (grant_act) begin
               d.cnt = 5'h00;
            end else if (count_done) begin
               d.state = lpmc_pkg::LPMC_BREQ;
            end else begin
               d.cnt = q.cnt + 5'h01;
            end
         end
         lpmc_pkg::LPMC_BREQ: begin
            // bus requested, waiting for the core's grant
            if (seq_abort) begin
               d.state = lpmc_pkg::LPMC_WAKE;
            end else if (!bus_grant_n) begin
               d.state = lpmc_pkg::LPMC_DOWN;
            end
         end
         lpmc_pkg::LPMC_DOWN: begin
            if (wake) begin
               d.state = lpmc_pkg::LPMC_WAKE;
            end
         end
         lpmc_pkg::LPMC_WAKE: begin
            d.state = lpmc_pkg::LPMC_RUN;
         end
         default: begin
            d.state = lpmc_pkg::LPMC_RUN;
         end
      endcase

      if (reg_rd) begin
         case (reg_addr)
            lpmc_pkg::OPERATION_MODE_CONTROL_OFF: begin
               d.rdata = q.omc;
            end
            lpmc_pkg::POWER_DOWN_BUS_DRIVE_OFF: begin
               d.rdata = q.pdb & 8'h07;
            end
            lpmc_pkg::POWER_DOWN_OPERAND_OFF: begin
               d.rdata = q.pdo;
            end
            lpmc_pkg::WAKE_UP_CONTROL_OFF: begin
               // bits 7 and 3 always read zero
               d.rdata = q.wuc & 8'h77;
            end
            default: begin
               d.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.state <= lpmc_pkg::LPMC_RUN;
         q.omc <= lpmc_pkg::OMC_RESET;
         q.pdb <= lpmc_pkg::PDB_RESET;
         q.pdo <= lpmc_pkg::PDO_RESET;
         q.wuc <= lpmc_pkg::WUC_RESET;
         q.pa_s1 <= 1'b1;
         q.pa_s2 <= 1'b1;
         q.pa_s3 <= 1'b1;
         q.pb_s1 <= 1'b1;
         q.pb_s2 <= 1'b1;
         q.pb_s3 <= 1'b1;
         q.hr_s1 <= 1'b1;
         q.hr_s2 <= 1'b1;
         q.ht_s1 <= 1'b1;
         q.ht_s2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      reg_rdata = q.rdata;
      bus_request_n = !(q.state == lpmc_pkg::LPMC_BREQ
                        || q.state == lpmc_pkg::LPMC_DOWN);
      clocks_stopped = q.state == lpmc_pkg::LPMC_DOWN;
      power_mode = clocks_stopped ? q.omc[1:0] : lpmc_pkg::LPM_NORMAL;
      slow_mode = df != 4'h0;
      sys_clk_tick = q.div_tick && !clocks_stopped;
      serial_rate_tick = serial_rate_clk_en
                         && (!q.omc[lpmc_pkg::OMC_HALF_BIT] || q.half_tog);
   end

   // ----------------------------------------------------------------
   // wake interrupts
   // ----------------------------------------------------------------
   always_comb begin
      wake_pin_a_irq = live[0];
      wake_pin_b_irq = live[1];
      timer_wake_irq = live[2];
      wake_irq_level = (|live) ? lpmc_pkg::WAKE_IRQ_LEVEL : 3'h0;
   end

   // ----------------------------------------------------------------
   // bus drive during power-down
   // ----------------------------------------------------------------
   always_comb begin
      // buses float unless stopped with drive enabled
      data_bus_oe = clocks_stopped && q.pdb[lpmc_pkg::PDB_EN_BIT];
      addr_bus_oe = data_bus_oe;
      data_bus_level = !q.pdb[lpmc_pkg::PDB_DL_BIT];
      addr_bus_level = !q.pdb[lpmc_pkg::PDB_AL_BIT];
   end
endmodule
`default_nettype wire

// *** verification/lpmc_assertions.sv ***
// concurrent checks on the low power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module lpmc_assertions (
   input wire logic       ref_clk, arst_n, bus_grant_n,
   input wire logic       bus_grant_acknowledge_n, bus_request_n,
   input wire logic       clocks_stopped, serial_rate_clk_en,
   input wire logic       serial_rate_tick, sys_clk_tick,
   input wire logic       data_bus_oe, addr_bus_oe, wake_pin_a_irq,
   input wire logic       wake_pin_b_irq, timer_wake_irq,
   input wire logic [1:0] power_mode,
   input wire logic [2:0] wake_irq_level
);
   logic [4:0] quiet_q;
   logic       live;
   assign live = wake_pin_a_irq | wake_pin_b_irq | timer_wake_irq;
   // cycles since the last grant activity, saturating
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         quiet_q <= 5'h00;
      else if (!bus_grant_n || !bus_grant_acknowledge_n)
         quiet_q <= 5'h00;
      else if (quiet_q != 5'h1f)
         quiet_q <= quiet_q + 5'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   req_after_quiet_a: assert property ($fell(bus_request_n) |-> quiet_q >= 5'h10)
      else $error("bus request before sixteen quiet clocks");
   stop_after_grant_a: assert property ($rose(clocks_stopped) |-> !$past(bus_grant_n) && !$past(bus_request_n))
      else $error("clocks stopped without grant");
   stopped_holds_req_a: assert property (clocks_stopped |-> !bus_request_n)
      else $error("bus released while stopped");
   mode_when_stopped_a: assert property ((power_mode != 2'h0) == clocks_stopped)
      else $error("power mode output wrong");
   oe_only_stopped_a: assert property ((data_bus_oe || addr_bus_oe) |-> clocks_stopped)
      else $error("bus driven outside power-down");
   oe_paired_a: assert property (data_bus_oe == addr_bus_oe)
      else $error("data and address drive differ");
   wake_level_a: assert property (wake_irq_level == (live ? 3'h4 : 3'h0))
      else $error("wake interrupt level wrong");
   wake_exit_a: assert property (clocks_stopped && live |-> ##[1:3] !clocks_stopped)
      else $error("no exit on live wake source");
   no_entry_live_a: assert property ($rose(clocks_stopped) |-> !$past(live))
      else $error("power-down entered with live source");
   rate_tick_a: assert property (serial_rate_tick |-> serial_rate_clk_en)
      else $error("rate tick without rate clock");
   sys_tick_off_a: assert property (clocks_stopped && $past(clocks_stopped) |-> !sys_clk_tick)
      else $error("system tick while stopped");
endmodule
bind lpmc_controller lpmc_assertions i_chk (.ref_clk, .arst_n,
   .bus_grant_n, .bus_grant_acknowledge_n, .bus_request_n, .clocks_stopped,
   .serial_rate_clk_en, .serial_rate_tick, .sys_clk_tick, .data_bus_oe,
   .addr_bus_oe, .wake_pin_a_irq, .wake_pin_b_irq, .timer_wake_irq,
   .power_mode, .wake_irq_level);
`default_nettype wire

// *** verification/lpmc_core_model.sv ***
// host core model answering bus requests with a grant
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
   input  wire logic       ref_clk, arst_n, bus_request_n,
   input  wire logic [1:0] grant_delay,
   output logic            bus_grant_n
);
   int wait_n;
   // grant after a few cycles, withdrawn with the request
   always @(negedge ref_clk or negedge arst_n) begin
      if (!arst_n || bus_request_n) begin
         bus_grant_n <= 1'b1;
         wait_n <= 0;
      end else if (wait_n >= grant_delay)
         bus_grant_n <= 1'b0;
      else
         wait_n <= wait_n + 1;
   end
endmodule
`default_nettype wire

// *** verification/lpmc_bench.sv ***
// self-checking bench of the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_bench;
   logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, stop_exec = 0;
   logic bus_grant_acknowledge_n = 1, wake_pin_a = 1, wake_pin_b = 1;
   logic hard_reset_n = 1, halt_n = 1, timer_timeout = 0;
   logic serial_rate_clk_en = 0, bus_grant_n, bus_request_n;
   logic serial_rate_tick, sys_clk_tick, slow_mode, clocks_stopped;
   logic wake_pin_a_irq, wake_pin_b_irq, timer_wake_irq, data_bus_oe;
   logic data_bus_level, addr_bus_oe, addr_bus_level;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic [2:0]  reg_fc = 3'h5, core_irq_level = 3'h0, wake_irq_level;
   logic [1:0]  power_mode, grant_delay = 2'h0;
   int n_errors = 0, tests_run = 0, n, cnt, omc_m, pdb_m;
   logic [11:0] offs [5] = '{lpmc_pkg::WAKE_UP_CONTROL_OFF,
      lpmc_pkg::OPERATION_MODE_CONTROL_OFF, lpmc_pkg::POWER_DOWN_OPERAND_OFF,
      lpmc_pkg::POWER_DOWN_BUS_DRIVE_OFF, 12'h123};
   localparam logic [11:0] OMC = lpmc_pkg::OPERATION_MODE_CONTROL_OFF;
   localparam logic [11:0] WUC = lpmc_pkg::WAKE_UP_CONTROL_OFF;
   localparam logic [11:0] PDO = lpmc_pkg::POWER_DOWN_OPERAND_OFF;
   always #12.5 ref_clk = ~ref_clk;
   lpmc_controller i_dut (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_fc, .reg_rdata, .stop_exec, .core_irq_level,
      .bus_grant_n, .bus_grant_acknowledge_n, .bus_request_n, .wake_pin_a,
      .wake_pin_b, .hard_reset_n, .halt_n, .timer_timeout,
      .serial_rate_clk_en, .serial_rate_tick, .sys_clk_tick, .slow_mode,
      .power_mode, .clocks_stopped, .wake_irq_level, .wake_pin_a_irq,
      .wake_pin_b_irq, .timer_wake_irq, .data_bus_oe, .data_bus_level,
      .addr_bus_oe, .addr_bus_level);
   lpmc_core_model i_core (.ref_clk, .arst_n, .bus_request_n, .grant_delay,
      .bus_grant_n);
   task automatic stop_test;
      $display("mismatches %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [2:0] fc);
      @(negedge ref_clk);
      {reg_wr, reg_addr, reg_wdata, reg_fc} = {1'b1, a, d, fc};
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge ref_clk);
      reg_rd = 1'b0;
      check(reg_rdata, exp);
   endtask
   // bounded wait on request (w 0) or stopped (w 1), one step a cycle
   task automatic wait_sig(input int w, input logic v, input int lim, input bit must, output int k);
      for (k = 0; k < lim; k++) begin
         if (((w == 0) ? bus_request_n : clocks_stopped) === v)
            break;
         @(negedge ref_clk);
      end
      if (must && k == lim) begin
         check(8'h00, 8'h01);
         stop_test();
      end
   endtask
   initial begin
      void'($urandom(32'h831a));
      repeat (10) @(negedge ref_clk);
      arst_n = 1'b1;
      foreach (offs[i]) rdc(offs[i], 8'h00);
      for (int df = 0; df < 4; df++) begin
         wr(OMC, 8'(df << 3), 3'h5);
         rdc(OMC, 8'(df << 3));
         cnt = 0;
         repeat (64) begin
            @(negedge ref_clk);
            cnt += int'(sys_clk_tick === 1'b1);
         end
         n = cnt - (64 >> df);
         check(8'(n * n <= 1), 8'h01);
         check(8'(slow_mode), 8'(df != 0));
      end
      for (int h = 0; h < 2; h++) begin
         wr(OMC, 8'(h << 2), 3'h5);
         cnt = 0;
         repeat (32) begin
            @(negedge ref_clk);
            serial_rate_clk_en = ~serial_rate_clk_en;
            #1 cnt += int'(serial_rate_tick === 1'b1);
         end
         check(8'(cnt), 8'(h ? 8 : 16));
      end
      wr(WUC, 8'h07, 3'h5);
      for (int s = 0; s < 4; s++) begin
         pdb_m = $urandom_range(7, 0);
         omc_m = (s % 3) + 9;
         grant_delay = 2'($urandom_range(3, 0));
         wr(OMC, 8'(omc_m), 3'h5);
         wr(lpmc_pkg::POWER_DOWN_BUS_DRIVE_OFF, 8'(pdb_m), 3'h5);
         wr(PDO, 8'h27, 3'h5);
         if (s == 3) begin
            repeat (5) @(negedge ref_clk);
            bus_grant_acknowledge_n = 1'b0;
            @(negedge ref_clk);
            bus_grant_acknowledge_n = 1'b1;
         end
         wait_sig(0, 1'b0, 60, 1'b1, n);
         check(8'(n), 8'h10);
         wait_sig(1, 1'b1, 10, 1'b1, n);
         check(8'(power_mode), 8'(omc_m & 3));
         check(8'({data_bus_oe, data_bus_level, addr_bus_oe, addr_bus_level}),
            8'({pdb_m[0], !pdb_m[1], pdb_m[0], !pdb_m[2]}));
         case (s)
            0: wake_pin_a = 1'b0;
            1: wake_pin_b = 1'b0;
            2: timer_timeout = 1'b1;
            default: {hard_reset_n, halt_n} = 2'b00;
         endcase
         repeat (3) @(negedge ref_clk);
         {timer_timeout, hard_reset_n, halt_n} = 3'b011;
         wait_sig(1, 1'b0, 20, 1'b1, n);
         if (s < 3) begin
            check(8'({timer_wake_irq, wake_pin_b_irq, wake_pin_a_irq}), 8'(1 << s));
            check(8'(wake_irq_level), 8'h04);
            wr(WUC, 8'h07, 3'h5);
            rdc(WUC, 8'h07 | (8'h10 << s));
            wr(WUC, 8'h07 | (8'h10 << s), 3'h5);
            rdc(WUC, 8'h07);
         end
         {wake_pin_a, wake_pin_b} = 2'b11;
         repeat (4) @(negedge ref_clk);
      end
      // refused entries: user space, higher interrupt, live wake source,
      // and a timer wake while the core finishes its stop
      for (int r = 0; r < 4; r++) begin
         core_irq_level = (r == 1) ? 3'h3 : 3'h0;
         wake_pin_a = (r != 2);
         repeat (5) @(negedge ref_clk);
         if (r == 3)
            wr(WUC, 8'h17, 3'h5);
         wr(PDO, (r == 1) ? 8'h22 : 8'h27, (r == 0) ? 3'h1 : 3'h5);
         if (r == 3) begin
            repeat (4) @(negedge ref_clk);
            timer_timeout = 1'b1;
            @(negedge ref_clk);
            timer_timeout = 1'b0;
         end
         wait_sig(0, 1'b0, 40, 1'b0, n);
         check(8'(n), 8'h28);
      end
      rdc(WUC, 8'h47);
      wr(OMC, 8'h81, 3'h5);
      rdc(OMC, 8'h81);
      wr(OMC, 8'h12, 3'h5);
      rdc(OMC, 8'h81);
      stop_test();
   end
endmodule
`default_nettype wire
